// File: ics_pkg.sv
// Constants, field layouts and carrier types of the interpolator config set
package ics_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG_ONE   = 8'h00;
  localparam logic [7:0] OFS_CFG_TWO   = 8'h04;
  localparam logic [7:0] OFS_CFG_THREE = 8'h08;
  localparam logic [7:0] OFS_IFACE     = 8'h0C;
  localparam logic [7:0] OFS_RATE      = 8'h10;
  localparam logic [7:0] OFS_PRESET1   = 8'h14;
  localparam logic [7:0] OFS_PRESET2   = 8'h18;
  localparam logic [7:0] OFS_ABS_OFFS  = 8'h1C;
  localparam logic [7:0] OFS_DEV_ADDR  = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;

  // config_word_one fields
  localparam int C1_DIV = 0;   // output_rate_divider [1:0]
  localparam int C1_D2E = 2;   // channel2_divider_enable
  localparam int C1_MAP = 3;   // rate_table_source
  localparam int C1_MOD = 4;   // operating mode [7:4]
  localparam int C1_TPP = 8;   // min_edge_spacing [10:8]
  localparam int C1_GAI = 11;  // nominal_amplitude_code [12:11]
  localparam int C1_FLT = 13;  // filter_select [14:13]
  localparam int C1_HLD = 15;  // hold_on_fault
  localparam int C1_TRI = 16;  // float outputs on fault
  localparam int C1_TRG = 17;  // strobe_edge_polarity, 0 = falling
  localparam int C1_MSK = 18;  // error masks [26:18]
  // config_word_two fields
  localparam int C2_PH1 = 0;   // phase_trim_ch1 [5:0]
  localparam int C2_PH2 = 6;   // phase_trim_ch2 [11:6]
  localparam int C2_SPN = 12;  // phase_span_select
  localparam int C2_Z4  = 13;  // reference_wide_pulse
  localparam int C2_ZPO = 14;  // reference_angle [18:14]
  localparam int C2_ZMO = 19;  // reference_behaviour [20:19]
  localparam int C2_PRE = 21;  // preset_enable
  localparam int C2_ASY = 22;  // port_free_running_select
  localparam int C2_MON = 23;  // monitor_output_off
  localparam int C2_V0  = 24;  // mean_voltage_off
  // config_word_three fields
  localparam int C3_DV2 = 0;   // channel2_rate_divider [1:0]
  localparam int C3_DH  = 2;   // hysteresis_steps [4:2]
  localparam int C3_DSZ = 5;   // reference_disable per channel [6:5]
  localparam int C3_ZDL = 7;   // reference_delay [8:7]
  localparam int C3_NOS = 9;   // vernier_reference_select
  localparam int C3_CEN = 10;  // correction_enable
  localparam int C3_CRS = 11;  // correction_resolution [12:11]
  localparam int C3_ALT = 13;  // amplitude_loop_timing [14:13]
  localparam int C3_OLT = 15;  // offset_loop_timing [16:15]
  localparam int C3_LDS = 17;  // loop_disable
  localparam int C3_CH2 = 18;  // second_channel_off
  localparam int C3_LAT = 19;  // error latch enables [27:19]
  // interface_config_word fields
  localparam int IF_SHF = 0;   // short_frame_format, 20-bit
  localparam int IF_RNG = 1;   // ring mode
  localparam int IF_STB = 2;   // status_bit_append
  localparam int IF_SRC = 3;   // position_source_select [4:3]
  localparam int IF_W32 = 5;   // wide_register_access
  localparam int IF_DIR = 6;   // direct output
  localparam int IF_STO = 8;   // shift_timeout [17:8]
  localparam int IF_BTO = 18;  // bidir_timeout [27:18]
  localparam int IF_SSI = 31;  // shift-only link select

  // Link timeouts, counted at the link reference rate
  localparam int LINK_REF_KHZ   = 26000;
  localparam int SHIFT_TO_NS    = 20000;
  localparam int BIDIR_TO_NS    = 19700;
  localparam logic [9:0] SHIFT_TO_CNT =
    10'(SHIFT_TO_NS * LINK_REF_KHZ / 1000000);
  localparam logic [9:0] BIDIR_TO_CNT =
    10'(BIDIR_TO_NS * LINK_REF_KHZ / 1000000);

  // Reset values
  localparam logic [31:0] CFG_ONE_RST   = 32'h0000_8008;
  localparam logic [31:0] CFG_TWO_RST   = 32'h0000_0000;
  localparam logic [31:0] CFG_THREE_RST = 32'h0000_A004;
  localparam logic [31:0] IFACE_RST     = {4'h0, BIDIR_TO_CNT,
                                           SHIFT_TO_CNT, 8'h43};
  localparam logic [15:0] RATE_EE_RST   = 16'h1F40;  // 8000
  localparam logic [15:0] RATE_PIN      = 16'h07D0;  // 2000
  localparam logic [7:0]  PITCH_RST     = 8'h7D;     // 125
  localparam logic [31:0] RATE_RST      = {8'h00, PITCH_RST, RATE_EE_RST};

  // Store layout
  localparam logic [15:0] EE_MARKER = 16'h134A;
  localparam logic [2:0]  EE_MARK_AT = 3'h0;
  localparam logic [2:0]  EE_LAST    = 3'h5;

  // Operating modes, low three bits of the mode field
  localparam logic [2:0] MODE_VERNIER = 3'h0;
  localparam logic [2:0] MODE_TWO_CH  = 3'h1;
  localparam logic [2:0] MODE_CALIB   = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ICS_INIT = 2'h0,
    ICS_LOAD = 2'h1,
    ICS_RUN  = 2'h3
  } ics_state_e;

  typedef enum logic [1:0] {
    ICS_M_VERNIER = 2'h0,
    ICS_M_TWO_CH  = 2'h1,
    ICS_M_CALIB   = 2'h2,
    ICS_M_UNDEF   = 2'h3
  } ics_mode_e;

  // Interpreted view of the configuration
  typedef struct packed {
    ics_mode_e  mode;
    logic       master_port_on;
    logic [7:0] edge_spacing;
    logic       hyst_on;
    logic [9:0] amp_mv;
    logic [7:0] filter_khz;
    logic       filter_bypass;
    logic [1:0] ch1_divider;
    logic [1:0] ch2_divider;
    logic       phase_wide_span;
    logic [3:0] dev_addr;
    logic       count_dir;
    logic       pin_config;
  } ics_view_s;

endpackage

// File: ics_config_set.sv
// Configuration register set with store or pin load and AXI4-Lite access
// Functional notes
// - Store load sets config, interface and rate words; bus writes set every field except count direction, and preset enable under pins; pins set only a subset
// - Store word zero must hold the marker, else pin configuration is used
// - Gain code selects 660, 250, 120 or 60 mVpp; from pins if pin load
// - Filter code selects 150, 75, 10 kHz or bypass; from pins if pin load
// - Edge spacing code picks 1 to 128 in powers of two, default 0
// - Hysteresis code 0 disables, 1 to 7 select levels, default 1
// - Two six-bit phase trims plus one span select bit
// - Reference enable, delay, width, angle and behaviour fields
// - Device address 0 to 15 from pins or the set-address command
// - Rate divider, with separate channel 2 divider when enabled
// - Four-bit mode; top bit enables master port on channel 2 pins
// - Rate 8000 from store or 2000 from pins, pitch 125, loops timing 01
// - Output defaults: edge code 0, hysteresis 1, hold, no error bits
// - Per-source mask and latch bits, plus hold or float on fault
// - Preset off, values zero, falling strobe; pins keep preset off
// - Link defaults: 20 us and 19.7 us timeouts, ring, 20-bit, direct
// - Wide register access select and free-running port select bits
// - Power-off switches for monitors, mean voltage, channel 2, refs
// - Mode field offers vernier, two-channel and calibration modes
`timescale 1ns/1ps
module ics_config_set
  import ics_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic [1:0]  GAIN_SELECT_PINS,
  input  wire logic [1:0]  FILTER_SELECT_PINS,
  input  wire logic [3:0]  DEVICE_ADDRESS_PINS,
  input  wire logic        COUNT_DIRECTION_PIN,
  output logic      [2:0]  EE_ADDR,
  input  wire logic [31:0] EE_RDATA,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      CFG_ONE,
  output logic [31:0]      CFG_TWO,
  output logic [31:0]      CFG_THREE,
  output logic [31:0]      IFACE_CFG,
  output logic [31:0]      RATE_CFG,
  output logic [31:0]      PRESET_ONE,
  output logic [31:0]      PRESET_TWO,
  output logic [31:0]      ABS_OFFSET,
  output ics_view_s        VIEW
);

  typedef struct packed {
    ics_state_e  st;
    logic [2:0]  ee_idx;
    logic        pin_cfg;
    logic [31:0] config_word_one;
    logic [31:0] config_word_two;
    logic [31:0] config_word_three;
    logic [31:0] iface;
    logic [31:0] rate;
    logic [31:0] pre1;
    logic [31:0] pre2;
    logic [31:0] offs;
    logic [3:0]  hw_addr;
    logic        count_dir;
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } ics_regs_s;

  localparam ics_regs_s REGS_RST = '{
    st: ICS_INIT, ee_idx: EE_MARK_AT, pin_cfg: 1'b0,
    config_word_one: CFG_ONE_RST, config_word_two: CFG_TWO_RST, config_word_three: CFG_THREE_RST,
    iface: IFACE_RST, rate: RATE_RST, pre1: 32'h0000_0000,
    pre2: 32'h0000_0000, offs: 32'h0000_0000, hw_addr: 4'h0,
    count_dir: 1'b0, aw_ok: 1'b0, aw_addr: 8'h00, w_ok: 1'b0,
    w_data: 32'h0000_0000, w_strb: 4'h0, bvalid: 1'b0,
    bresp: RESP_OKAY, rvalid: 1'b0, rresp: RESP_OKAY,
    rdata: 32'h0000_0000};

  ics_regs_s r_reg;
  ics_regs_s r_next;
  logic [31:0] wmask;
  logic        run;
  logic        wr_fire;
  logic        marker_ok;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes; nothing is taken until configuration load is over

  assign run           = (r_reg.st == ICS_RUN) && CE;
  assign S_AXI_AWREADY = run && !r_reg.aw_ok;
  assign S_AXI_WREADY  = run && !r_reg.w_ok;
  assign S_AXI_ARREADY = run && !r_reg.rvalid;
  assign wr_fire       = run && r_reg.aw_ok && r_reg.w_ok && !r_reg.bvalid;
  assign marker_ok     = (EE_RDATA[15:0] == EE_MARKER);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{r_reg.w_strb[gi]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (r_reg.w_data & wmask);
  endfunction

  function automatic logic [31:0] status_word(input ics_regs_s s);
    status_word = {24'h00_0000, s.count_dir, s.pin_cfg, s.st, s.hw_addr};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    r_next = r_reg;
    if (CE)
    begin
      case (r_reg.st)
        ICS_INIT:
        begin
          // Pins caught on the first edge after release
          r_next.count_dir = COUNT_DIRECTION_PIN;
          r_next.hw_addr   = DEVICE_ADDRESS_PINS;
          if (marker_ok)
          begin
            r_next.st      = ICS_LOAD;
            r_next.ee_idx  = 3'h1;
            r_next.pin_cfg = 1'b0;
          end
          else
          begin
            r_next.st      = ICS_RUN;
            r_next.pin_cfg = 1'b1;
            r_next.config_word_one[C1_GAI +: 2] = GAIN_SELECT_PINS;
            r_next.config_word_one[C1_FLT +: 2] = FILTER_SELECT_PINS;
            r_next.rate[15:0] = RATE_PIN;
          end
        end
        ICS_LOAD:
        begin
          case (r_reg.ee_idx)
            3'h1:    r_next.config_word_one  = EE_RDATA;
            3'h2:    r_next.config_word_two  = EE_RDATA;
            3'h3:    r_next.config_word_three  = EE_RDATA;
            3'h4:    r_next.iface = EE_RDATA;
            3'h5:    r_next.rate  = EE_RDATA;
            default: r_next.rate  = r_reg.rate;
          endcase
          if (r_reg.ee_idx == EE_LAST)
          begin
            r_next.st     = ICS_RUN;
            r_next.ee_idx = EE_MARK_AT;
          end
          else
          begin
            r_next.ee_idx = r_reg.ee_idx + 3'h1;
          end
        end
        ICS_RUN:
        begin
          if (S_AXI_AWVALID && S_AXI_AWREADY)
          begin
            r_next.aw_ok   = 1'b1;
            r_next.aw_addr = S_AXI_AWADDR;
          end
          if (S_AXI_WVALID && S_AXI_WREADY)
          begin
            r_next.w_ok   = 1'b1;
            r_next.w_data = S_AXI_WDATA;
            r_next.w_strb = S_AXI_WSTRB;
          end
          if (wr_fire)
          begin
            r_next.aw_ok  = 1'b0;
            r_next.w_ok   = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = RESP_OKAY;
            case (r_reg.aw_addr)
              OFS_CFG_ONE:   r_next.config_word_one  = merge(r_reg.config_word_one);
              OFS_CFG_TWO:   r_next.config_word_two  = merge(r_reg.config_word_two);
              OFS_CFG_THREE: r_next.config_word_three  = merge(r_reg.config_word_three);
              OFS_IFACE:     r_next.iface = merge(r_reg.iface);
              OFS_RATE:      r_next.rate  = merge(r_reg.rate);
              OFS_PRESET1:   r_next.pre1  = merge(r_reg.pre1);
              OFS_PRESET2:   r_next.pre2  = merge(r_reg.pre2);
              OFS_ABS_OFFS:  r_next.offs  = merge(r_reg.offs);
              OFS_DEV_ADDR:
              begin
                if (r_reg.w_strb[0])
                begin
                  r_next.hw_addr = r_reg.w_data[3:0];
                end
              end
              OFS_STATUS:    r_next.bresp = RESP_OKAY;
              default:       r_next.bresp = RESP_SLVERR;
            endcase
          end
          else if (r_reg.bvalid && S_AXI_BREADY)
          begin
            r_next.bvalid = 1'b0;
          end
          // Preset cannot be switched on under pin configuration
          if (r_reg.pin_cfg)
          begin
            r_next.config_word_two[C2_PRE] = 1'b0;
          end
          if (S_AXI_ARVALID && S_AXI_ARREADY)
          begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = RESP_OKAY;
            case (S_AXI_ARADDR)
              OFS_CFG_ONE:   r_next.rdata = r_reg.config_word_one;
              OFS_CFG_TWO:   r_next.rdata = r_reg.config_word_two;
              OFS_CFG_THREE: r_next.rdata = r_reg.config_word_three;
              OFS_IFACE:     r_next.rdata = r_reg.iface;
              OFS_RATE:      r_next.rdata = r_reg.rate;
              OFS_PRESET1:   r_next.rdata = r_reg.pre1;
              OFS_PRESET2:   r_next.rdata = r_reg.pre2;
              OFS_ABS_OFFS:  r_next.rdata = r_reg.offs;
              OFS_DEV_ADDR:  r_next.rdata = {28'h000_0000, r_reg.hw_addr};
              OFS_STATUS:    r_next.rdata = status_word(r_reg);
              default:
              begin
                r_next.rdata = 32'h0000_0000;
                r_next.rresp = RESP_SLVERR;
              end
            endcase
          end
          else if (r_reg.rvalid && S_AXI_RREADY)
          begin
            r_next.rvalid = 1'b0;
          end
        end
        default:
        begin
          r_next.st = ICS_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      r_reg <= REGS_RST;
    else
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign EE_ADDR      = r_reg.ee_idx;
  assign S_AXI_BVALID = r_reg.bvalid;
  assign S_AXI_BRESP  = r_reg.bresp;
  assign S_AXI_RVALID = r_reg.rvalid;
  assign S_AXI_RRESP  = r_reg.rresp;
  assign S_AXI_RDATA  = r_reg.rdata;
  // Raw words carry trims, reference, mask, latch and power-off fields
  assign CFG_ONE      = r_reg.config_word_one;
  assign CFG_TWO      = r_reg.config_word_two;
  assign CFG_THREE    = r_reg.config_word_three;
  assign IFACE_CFG    = r_reg.iface;
  assign RATE_CFG     = r_reg.rate;
  assign PRESET_ONE   = r_reg.pre1;
  assign PRESET_TWO   = r_reg.pre2;
  assign ABS_OFFSET   = r_reg.offs;

  // Pure decode of flip-flops, no added state
  always_comb
  begin
    VIEW = '0;
    case (r_reg.config_word_one[C1_MOD +: 3])
      MODE_VERNIER: VIEW.mode = ICS_M_VERNIER;
      MODE_TWO_CH:  VIEW.mode = ICS_M_TWO_CH;
      MODE_CALIB:   VIEW.mode = ICS_M_CALIB;
      default:      VIEW.mode = ICS_M_UNDEF;
    endcase
    VIEW.master_port_on = r_reg.config_word_one[C1_MOD + 3];
    VIEW.edge_spacing = 8'h01 << r_reg.config_word_one[C1_TPP +: 3];
    VIEW.hyst_on = (r_reg.config_word_three[C3_DH +: 3] != 3'h0);
    case (r_reg.config_word_one[C1_GAI +: 2])
      2'h0:    VIEW.amp_mv = 10'h294;
      2'h1:    VIEW.amp_mv = 10'h0FA;
      2'h2:    VIEW.amp_mv = 10'h078;
      default: VIEW.amp_mv = 10'h03C;
    endcase
    case (r_reg.config_word_one[C1_FLT +: 2])
      2'h0:    VIEW.filter_khz = 8'h96;
      2'h1:    VIEW.filter_khz = 8'h4B;
      2'h2:    VIEW.filter_khz = 8'h0A;
      default: VIEW.filter_khz = 8'h00;
    endcase
    VIEW.filter_bypass = (r_reg.config_word_one[C1_FLT +: 2] == 2'h3);
    VIEW.ch1_divider = r_reg.config_word_one[C1_DIV +: 2];
    VIEW.ch2_divider = r_reg.config_word_one[C1_D2E] ? r_reg.config_word_three[C3_DV2 +: 2]
                                          : r_reg.config_word_one[C1_DIV +: 2];
    VIEW.phase_wide_span = r_reg.config_word_two[C2_SPN];
    VIEW.dev_addr   = r_reg.hw_addr;
    VIEW.count_dir  = r_reg.count_dir;
    VIEW.pin_config = r_reg.pin_cfg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_marker_load: assert property (
    !RESET && r_reg.st == ICS_INIT && CE && marker_ok |=>
      r_reg.st == ICS_LOAD && !r_reg.pin_cfg)
    else $error("marker seen but store load not started");

  a_pin_fallback: assert property (
    !RESET && r_reg.st == ICS_INIT && CE && !marker_ok |=>
      r_reg.st == ICS_RUN && r_reg.pin_cfg && r_reg.rate[15:0] == RATE_PIN)
    else $error("pin configuration not applied");

  a_pin_gain_filter: assert property (
    !RESET && r_reg.st == ICS_INIT && CE && !marker_ok |=>
      r_reg.config_word_one[C1_GAI +: 2] == $past(GAIN_SELECT_PINS) &&
      r_reg.config_word_one[C1_FLT +: 2] == $past(FILTER_SELECT_PINS))
    else $error("gain or filter pins not captured");

  a_load_length: assert property (
    !RESET && r_reg.st == ICS_INIT && CE && marker_ok |=>
      ##5 (r_reg.st == ICS_RUN))
    else $error("store load took wrong number of cycles");

  a_preset_blocked: assert property (
    r_reg.pin_cfg && r_reg.st == ICS_RUN |=> !r_reg.config_word_two[C2_PRE])
    else $error("preset enabled under pin configuration");

  a_edge_spacing: assert property (
    r_reg.config_word_one[C1_TPP +: 3] == 3'h7 |-> VIEW.edge_spacing == 8'h80)
    else $error("edge spacing decode wrong");

  a_hyst_default: assert property (
    r_reg.st == ICS_INIT |->
      r_reg.config_word_three[C3_DH +: 3] == 3'h1 && VIEW.hyst_on)
    else $error("hysteresis default wrong");

  a_out_defaults: assert property (
    r_reg.st == ICS_INIT |-> r_reg.config_word_one[C1_HLD] &&
      r_reg.config_word_one[C1_MSK +: 9] == 9'h000 &&
      r_reg.config_word_three[C3_LAT +: 9] == 9'h000)
    else $error("output defaults wrong");

  a_link_defaults: assert property (
    r_reg.st == ICS_INIT |->
      r_reg.iface[IF_STO +: 10] == 10'h208 &&
      r_reg.iface[IF_BTO +: 10] == 10'h200)
    else $error("link timeout defaults wrong");

  a_addr_command: assert property (
    wr_fire && r_reg.aw_addr == OFS_DEV_ADDR && r_reg.w_strb[0] |=>
      r_reg.hw_addr == $past(r_reg.w_data[3:0]) && S_AXI_BVALID)
    else $error("address command not applied");

  a_ch2_divider: assert property (
    !r_reg.config_word_one[C1_D2E] |-> VIEW.ch2_divider == VIEW.ch1_divider)
    else $error("channel 2 divider not shared");

  c_store_load: cover property (
    r_reg.st == ICS_LOAD ##1 r_reg.st == ICS_LOAD);
  c_pin_load: cover property (
    r_reg.st == ICS_INIT ##1 r_reg.st == ICS_RUN && r_reg.pin_cfg);
  c_write_done: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_bad_read: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);

endmodule

// File: ics_store_model.sv
// Behavioural configuration store answering word reads in the same cycle
`timescale 1ns/1ps
module ics_store_model
  import ics_pkg::*;
(
  input  wire logic        marker_ok,
  input  wire logic [31:0] words [1:5],
  input  wire logic [2:0]  ee_addr,
  output logic      [31:0] ee_rdata
);
  // Bad marker differs in one bit only, the nearest miss
  always_comb
  begin
    if (ee_addr == EE_MARK_AT)
      ee_rdata = {16'h0000, marker_ok ? EE_MARKER
                                      : EE_MARKER ^ 16'h0001};
    else if (ee_addr <= EE_LAST)
      ee_rdata = words[ee_addr];
    else
      ee_rdata = {29'h0, ~ee_addr};
  end
endmodule

// File: testbench.sv
// Self-checking bench for the configuration set, store and bus side
`timescale 1ns/1ps
module testbench
  import ics_pkg::*;
;
  logic CLK = 0, RESET = 1, CE = 1, dp = 0, ok = 0;
  logic [1:0] gp = 0, fp = 0, bresp, rresp;
  logic [3:0] ap = 0;
  logic [2:0] ea;
  logic [31:0] ed, wdata = 0, rdata, v, d;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wrd, bv, arr, rv;
  logic [1:0] r;
  logic [31:0] words [1:5];
  logic [31:0] mdl [0:8];
  logic [31:0] mk [0:8] = '{32'h07FF_FFFF, 32'h01FF_FFFF, 32'h0FFF_FFFF,
    32'h8FFF_FF7F, 32'h00FF_FFFF, '1, '1, '1, 32'h0000_000F};
  int amp [0:3] = '{660, 250, 120, 60};
  int flt [0:3] = '{150, 75, 10, 0};
  int mt [0:2] = '{0, 1, 5};
  int fails = 0, n_compared = 0;
  ics_view_s view;
  logic [31:0] outs [0:7];

  always #50 CLK = ~CLK;

  ics_store_model u_ics_store_model (.marker_ok(ok), .words(words),
    .ee_addr(ea), .ee_rdata(ed));
  ics_config_set u_ics_config_set (.CLK(CLK), .RESET(RESET), .CE(CE),
    .GAIN_SELECT_PINS(gp), .FILTER_SELECT_PINS(fp),
    .DEVICE_ADDRESS_PINS(ap), .COUNT_DIRECTION_PIN(dp),
    .EE_ADDR(ea), .EE_RDATA(ed), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .CFG_ONE(outs[0]), .CFG_TWO(outs[1]),
    .CFG_THREE(outs[2]), .IFACE_CFG(outs[3]), .RATE_CFG(outs[4]),
    .PRESET_ONE(outs[5]), .PRESET_TWO(outs[6]), .ABS_OFFSET(outs[7]),
    .VIEW(view));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Readies sampled mid-cycle, where they are settled
  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    bit ta, tw, da, dw;
    da = 0;
    dw = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge CLK);
      ta = awv && awr === 1'b1;
      tw = wv && wrd === 1'b1;
      @(posedge CLK);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    while (r === 2'h3)
    begin
      @(negedge CLK);
      if (bv === 1'b1) r = bresp;
    end
    @(posedge CLK);
    bready <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic axr(input logic [7:0] a);
    bit ta;
    ta = 0;
    r = 2'h3;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (!ta)
    begin
      @(negedge CLK);
      ta = arr === 1'b1;
      @(posedge CLK);
      if (ta) arv <= 1'b0;
    end
    while (r === 2'h3)
    begin
      @(negedge CLK);
      if (rv === 1'b1) {d, r} = {rdata, rresp};
    end
    @(posedge CLK);
    rready <= 1'b0;
    @(posedge CLK);
  endtask

  // Pins and store contents change only while reset is held
  task automatic do_reset(input bit valid);
    {gp, fp, ap, dp} <= 9'($urandom);
    ok <= valid;
    for (int i = 1; i < 6; i++)
      words[i] <= $urandom & mk[i - 1] | 32'(i == 2) << C2_MON;
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    repeat (10) @(posedge CLK);
    mdl = '{CFG_ONE_RST, CFG_TWO_RST, CFG_THREE_RST, IFACE_RST, RATE_RST,
      '0, '0, '0, '0};
    for (int i = 0; i < 5 && valid; i++) mdl[i] = words[i + 1];
    if (!valid) mdl[0][C1_GAI +: 2] = gp;
    if (!valid) mdl[0][C1_FLT +: 2] = fp;
    if (!valid) mdl[4] = {8'h00, PITCH_RST, RATE_PIN};
    for (int i = 0; i < 8; i++)
    begin
      axr(8'(i * 4));
      chk(d, mdl[i]);
      chk(outs[i], mdl[i]);
    end
    axr(OFS_STATUS);
    chk(d, {24'h0, dp, ~valid, 2'h3, ap});
    chk(32'(view.count_dir), 32'(dp));
    chk(32'(view.pin_config), 32'(!valid));
    $display("test reset with store valid %0d done", valid);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hc4907fe9));
    do_reset(0);
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom & mk[i];
      if (i == 0) v[C1_FLT + 1] = 1'b0;
      if (i == 1) v[C2_MON] = 1'b1;
      axw(8'(i * 4), v);
      chk(32'(r), 32'(RESP_OKAY));
      if (i == 1) v[C2_PRE] = 1'b0;
      axr(8'(i * 4));
      chk(d, v);
      if (i == 1) chk(32'(view.phase_wide_span), 32'(v[C2_SPN]));
    end
    $display("test write and read back done");
    for (int i = 0; i < 8; i++)
    begin
      axw(OFS_CFG_ONE, 32'(mt[i % 3] << 4 | (i >> 2) << 7 | i << 8 |
        (i % 4) << 11 | (i % 4) << 13 | (i % 4) | (i % 2) << 2));
      axw(OFS_CFG_THREE, 32'(i << C3_DH | (3 - i % 4)));
      chk(32'(view.edge_spacing), 32'(1) << i);
      chk(32'(view.amp_mv), 32'(amp[i % 4]));
      chk(32'(view.filter_khz), 32'(flt[i % 4]));
      chk(32'(view.filter_bypass), 32'(i % 4 == 3));
      chk(32'(view.hyst_on), 32'(i != 0));
      chk(32'(view.mode), 32'(i % 3));
      chk(32'(view.master_port_on), 32'(i >> 2));
      chk(32'(view.ch1_divider), 32'(i % 4));
      chk(32'(view.ch2_divider), 32'(i % 2 ? 3 - i % 4 : i % 4));
    end
    $display("test decoded view done");
    axw(8'h30, 32'h5A5A_A5A5);
    chk(32'(r), 32'(RESP_SLVERR));
    axr(8'h30);
    chk({d[29:0], r}, 32'(RESP_SLVERR));
    v = $urandom % 16;
    axw(OFS_DEV_ADDR, v);
    chk(32'(view.dev_addr), v);
    CE <= 1'b0;
    @(negedge CLK);
    chk(32'({awr, wrd, arr}), 32'h0);
    @(posedge CLK);
    CE <= 1'b1;
    @(posedge CLK);
    $display("test unmapped and address command done");
    do_reset(1);
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    fails++;
    close_out;
  end
endmodule
